/* adc_ctrl_pkg.sv */
// Purpose: Shared constants and carrier types for the converter control block.
// Assumes: 8-bit register port, byte-wide registers at byte offsets.
// Notes: Offsets, field positions and reset values are named once here.
`default_nettype none

package adc_ctrl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] OFF_PERIPH_RESET = 8'h00;
  localparam logic [7:0] OFF_PERIPH_CLOCK = 8'h01;
  localparam logic [7:0] OFF_CONV_MODE = 8'h02;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h03;
  localparam logic [7:0] OFF_IRQ_REQUEST = 8'h04;
  localparam logic [7:0] OFF_PRIO_UPPER = 8'h05;
  localparam logic [7:0] OFF_PRIO_LOWER = 8'h06;
  localparam logic [7:0] OFF_PORT2_ANALOG = 8'h07;
  localparam logic [7:0] OFF_PORT2_DIR = 8'h08;
  localparam logic [7:0] OFF_RESULT_LOW = 8'h09;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h0a;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h0b;
  localparam logic [7:0] OFF_EVT_MASK = 8'h0c;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int BIT_CONVERTER_RESET_HOLD = 5;
  localparam int BIT_CONVERTER_CLOCK_GATE = 5;
  localparam int BIT_CONVERSION_RUN = 7;
  localparam int BIT_COMPARATOR_ENABLE = 0;
  localparam int BIT_CONV_END = 0;
  localparam int BIT_PIN0 = 0;
  localparam int BIT_EVT_END = 0;
  localparam int BIT_EVT_OVERRUN = 1;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed bits.
  localparam logic [7:0] RST_PERIPH_RESET = 8'h00;
  localparam logic [7:0] RST_PERIPH_CLOCK = 8'h00;
  localparam logic [7:0] RST_CONV_MODE = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'hff;
  localparam logic [7:0] RST_IRQ_REQUEST = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'hff;
  localparam logic [7:0] RST_PORT2 = 8'hff;
  localparam logic [1:0] RST_EVT = 2'h0;
  localparam logic [7:0] PERIPH_WRITE_MASK = 8'h75;
  localparam logic [7:0] PORT2_FIXED_ONES = 8'hf0;

  //////////////////////////////////////////////////////////////////////////////
  // Carrier types.
  typedef struct packed {
    logic reset_hold;
    logic clock_gate;
    logic run;
    logic comparator_enable;
  } conv_ctrl_t;

  typedef struct packed {
    logic analog_select;
    logic out_en;
  } pin_ctrl_t;

  typedef struct packed {
    logic request;
    logic [1:0] prio;
  } irq_req_t;

endpackage

`default_nettype wire

/* adc_ctrl.sv */
// Purpose: Register control around an on-chip converter, its end interrupt and pin 0.
// Assumes: conv_done and conv_data come from the converter clock and are synchronised.
// Notes: conv_data must be stable before conv_done rises and until it falls.
//
// Functional notes
// - Reset bit 1 holds converter in reset.
// - Clock gate 0 stops clock, blocks mode writes.
// - Run bit 1 enables, 0 stops conversion.
// - Run bit reads back converting or waiting; here it reads back the last accepted run write, or 0 after a reset hold, not conversion status.
// - Comparator bit enables the voltage comparator.
// - Mask bit 1 withholds end interrupt service.
// - End event sets flag; software writes 0.
// - Priority code from two registers, 00 highest.
// - Pin analog bit routes pin as input.
// - Direction 0 turns pin output buffer on.
// - Direction 1 turns pin output buffer off.
// - Each conversion end while clocked and not held stores result, raises request.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module adc_ctrl #(
  parameter int RESULT_W = 10
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [adc_ctrl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [RESULT_W-1:0] conv_data,
  output adc_ctrl_pkg::conv_ctrl_t conv_ctrl,
  output adc_ctrl_pkg::pin_ctrl_t pin0_ctrl,
  output adc_ctrl_pkg::irq_req_t conv_end_req,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and conversion end detection.
  logic done_s1_q, done_s1_d;
  logic done_s2_q, done_s2_d;
  logic done_s3_q, done_s3_d;
  logic [RESULT_W-1:0] data_s1_q, data_s1_d;
  logic [RESULT_W-1:0] data_s2_q, data_s2_d;

  always_comb begin
    done_s1_d = conv_done;
    done_s2_d = done_s1_q;
    done_s3_d = done_s2_q;
    data_s1_d = conv_data;
    data_s2_d = data_s1_q;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      data_s1_q <= '0;
      data_s2_q <= '0;
    end else begin
      done_s1_q <= done_s1_d;
      done_s2_q <= done_s2_d;
      done_s3_q <= done_s3_d;
      data_s1_q <= data_s1_d;
      data_s2_q <= data_s2_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0] periph_reset_ctrl_0_q, periph_reset_ctrl_0_d;
  logic [7:0] periph_clock_enable_0_q, periph_clock_enable_0_d;
  logic [7:0] converter_mode_0_q, converter_mode_0_d;
  logic [7:0] irq_mask_group1_high_q, irq_mask_group1_high_d;
  logic [7:0] irq_request_group1_high_q, irq_request_group1_high_d;
  logic [7:0] irq_priority_upper_bits_q, irq_priority_upper_bits_d;
  logic [7:0] irq_priority_lower_bits_q, irq_priority_lower_bits_d;
  logic [7:0] port2_analog_select_q, port2_analog_select_d;
  logic [7:0] port2_direction_q, port2_direction_d;
  logic [RESULT_W-1:0] conversion_result_q, conversion_result_d;
  logic result_unread_q, result_unread_d;
  logic [1:0] evt_status_q, evt_status_d;
  logic [1:0] evt_mask_q, evt_mask_d;
  logic converter_reset_hold;
  logic converter_clock_gate;
  logic conv_write_ok;
  logic done_evt;
  logic overrun_evt;
  logic [15:0] result_word;

  // The converter cannot finish while its clock is stopped or it is held in reset.
  assign converter_reset_hold = periph_reset_ctrl_0_q[adc_ctrl_pkg::BIT_CONVERTER_RESET_HOLD];
  assign converter_clock_gate = periph_clock_enable_0_q[adc_ctrl_pkg::BIT_CONVERTER_CLOCK_GATE];
  assign conv_write_ok = converter_clock_gate && !converter_reset_hold;
  assign done_evt = done_s2_q && !done_s3_q && conv_write_ok;
  assign overrun_evt = done_evt && result_unread_q;
  // Result is left-justified in a 16-bit word.
  assign result_word = {conversion_result_q, {(16 - RESULT_W){1'b0}}};

  always_comb begin
    periph_reset_ctrl_0_d = periph_reset_ctrl_0_q;
    periph_clock_enable_0_d = periph_clock_enable_0_q;
    converter_mode_0_d = converter_mode_0_q;
    irq_mask_group1_high_d = irq_mask_group1_high_q;
    irq_request_group1_high_d = irq_request_group1_high_q;
    irq_priority_upper_bits_d = irq_priority_upper_bits_q;
    irq_priority_lower_bits_d = irq_priority_lower_bits_q;
    port2_analog_select_d = port2_analog_select_q;
    port2_direction_d = port2_direction_q;
    conversion_result_d = conversion_result_q;
    result_unread_d = result_unread_q;
    evt_status_d = evt_status_q;
    evt_mask_d = evt_mask_q;
    if (reg_wr) begin
      if (reg_addr == adc_ctrl_pkg::OFF_PERIPH_RESET) begin
        periph_reset_ctrl_0_d = reg_wdata & adc_ctrl_pkg::PERIPH_WRITE_MASK;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PERIPH_CLOCK) begin
        periph_clock_enable_0_d = reg_wdata & adc_ctrl_pkg::PERIPH_WRITE_MASK;
      end else if (reg_addr == adc_ctrl_pkg::OFF_CONV_MODE) begin
        if (conv_write_ok) begin
          converter_mode_0_d = reg_wdata;
        end
      end else if (reg_addr == adc_ctrl_pkg::OFF_IRQ_MASK) begin
        irq_mask_group1_high_d = reg_wdata;
      end else if (reg_addr == adc_ctrl_pkg::OFF_IRQ_REQUEST) begin
        irq_request_group1_high_d = reg_wdata;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PRIO_UPPER) begin
        irq_priority_upper_bits_d = reg_wdata;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PRIO_LOWER) begin
        irq_priority_lower_bits_d = reg_wdata;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PORT2_ANALOG) begin
        port2_analog_select_d = reg_wdata | adc_ctrl_pkg::PORT2_FIXED_ONES;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PORT2_DIR) begin
        port2_direction_d = reg_wdata | adc_ctrl_pkg::PORT2_FIXED_ONES;
      end else if (reg_addr == adc_ctrl_pkg::OFF_EVT_MASK) begin
        evt_mask_d = reg_wdata[1:0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == adc_ctrl_pkg::OFF_RESULT_HIGH) begin
        result_unread_d = 1'b0;
      end else if (reg_addr == adc_ctrl_pkg::OFF_EVT_STATUS) begin
        evt_status_d = 2'h0;
      end
    end
    // Converter-side state returns to its reset value while the converter is held.
    if (converter_reset_hold) begin
      converter_mode_0_d = adc_ctrl_pkg::RST_CONV_MODE;
      conversion_result_d = '0;
      result_unread_d = 1'b0;
    end
    // Events are applied last so that a set wins over a clear in the same cycle.
    if (done_evt) begin
      conversion_result_d = data_s2_q;
      result_unread_d = 1'b1;
      irq_request_group1_high_d[adc_ctrl_pkg::BIT_CONV_END] = 1'b1;
      evt_status_d[adc_ctrl_pkg::BIT_EVT_END] = 1'b1;
    end
    if (overrun_evt) begin
      evt_status_d[adc_ctrl_pkg::BIT_EVT_OVERRUN] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      periph_reset_ctrl_0_q <= adc_ctrl_pkg::RST_PERIPH_RESET;
      periph_clock_enable_0_q <= adc_ctrl_pkg::RST_PERIPH_CLOCK;
      converter_mode_0_q <= adc_ctrl_pkg::RST_CONV_MODE;
      irq_mask_group1_high_q <= adc_ctrl_pkg::RST_IRQ_MASK;
      irq_request_group1_high_q <= adc_ctrl_pkg::RST_IRQ_REQUEST;
      irq_priority_upper_bits_q <= adc_ctrl_pkg::RST_PRIO;
      irq_priority_lower_bits_q <= adc_ctrl_pkg::RST_PRIO;
      port2_analog_select_q <= adc_ctrl_pkg::RST_PORT2;
      port2_direction_q <= adc_ctrl_pkg::RST_PORT2;
      conversion_result_q <= '0;
      result_unread_q <= 1'b0;
      evt_status_q <= adc_ctrl_pkg::RST_EVT;
      evt_mask_q <= adc_ctrl_pkg::RST_EVT;
    end else begin
      periph_reset_ctrl_0_q <= periph_reset_ctrl_0_d;
      periph_clock_enable_0_q <= periph_clock_enable_0_d;
      converter_mode_0_q <= converter_mode_0_d;
      irq_mask_group1_high_q <= irq_mask_group1_high_d;
      irq_request_group1_high_q <= irq_request_group1_high_d;
      irq_priority_upper_bits_q <= irq_priority_upper_bits_d;
      irq_priority_lower_bits_q <= irq_priority_lower_bits_d;
      port2_analog_select_q <= port2_analog_select_d;
      port2_direction_q <= port2_direction_d;
      conversion_result_q <= conversion_result_d;
      result_unread_q <= result_unread_d;
      evt_status_q <= evt_status_d;
      evt_mask_q <= evt_mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data and registered outputs.
  logic [7:0] rdata_d;
  adc_ctrl_pkg::conv_ctrl_t conv_ctrl_d;
  adc_ctrl_pkg::pin_ctrl_t pin0_ctrl_d;
  adc_ctrl_pkg::irq_req_t conv_end_req_d;
  logic irq_d;

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      if (reg_addr == adc_ctrl_pkg::OFF_PERIPH_RESET) begin
        rdata_d = periph_reset_ctrl_0_q;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PERIPH_CLOCK) begin
        rdata_d = periph_clock_enable_0_q;
      end else if (reg_addr == adc_ctrl_pkg::OFF_CONV_MODE) begin
        rdata_d = converter_mode_0_q;
      end else if (reg_addr == adc_ctrl_pkg::OFF_IRQ_MASK) begin
        rdata_d = irq_mask_group1_high_q;
      end else if (reg_addr == adc_ctrl_pkg::OFF_IRQ_REQUEST) begin
        rdata_d = irq_request_group1_high_q;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PRIO_UPPER) begin
        rdata_d = irq_priority_upper_bits_q;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PRIO_LOWER) begin
        rdata_d = irq_priority_lower_bits_q;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PORT2_ANALOG) begin
        rdata_d = port2_analog_select_q;
      end else if (reg_addr == adc_ctrl_pkg::OFF_PORT2_DIR) begin
        rdata_d = port2_direction_q;
      end else if (reg_addr == adc_ctrl_pkg::OFF_RESULT_LOW) begin
        rdata_d = result_word[7:0];
      end else if (reg_addr == adc_ctrl_pkg::OFF_RESULT_HIGH) begin
        rdata_d = result_word[15:8];
      end else if (reg_addr == adc_ctrl_pkg::OFF_EVT_STATUS) begin
        rdata_d = {6'h00, evt_status_q};
      end else if (reg_addr == adc_ctrl_pkg::OFF_EVT_MASK) begin
        rdata_d = {6'h00, evt_mask_q};
      end
    end
    conv_ctrl_d.reset_hold =
      periph_reset_ctrl_0_d[adc_ctrl_pkg::BIT_CONVERTER_RESET_HOLD];
    conv_ctrl_d.clock_gate =
      periph_clock_enable_0_d[adc_ctrl_pkg::BIT_CONVERTER_CLOCK_GATE];
    conv_ctrl_d.run = converter_mode_0_d[adc_ctrl_pkg::BIT_CONVERSION_RUN];
    conv_ctrl_d.comparator_enable =
      converter_mode_0_d[adc_ctrl_pkg::BIT_COMPARATOR_ENABLE];
    pin0_ctrl_d.analog_select = port2_analog_select_d[adc_ctrl_pkg::BIT_PIN0];
    // The buffer is on only while the pin is an output; direction 1 turns it off.
    pin0_ctrl_d.out_en = !port2_direction_d[adc_ctrl_pkg::BIT_PIN0];
    conv_end_req_d.request = irq_request_group1_high_d[adc_ctrl_pkg::BIT_CONV_END]
      && !irq_mask_group1_high_d[adc_ctrl_pkg::BIT_CONV_END];
    conv_end_req_d.prio = {irq_priority_upper_bits_d[adc_ctrl_pkg::BIT_CONV_END],
      irq_priority_lower_bits_d[adc_ctrl_pkg::BIT_CONV_END]};
    irq_d = |(evt_status_d & evt_mask_d);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      conv_ctrl <= '0;
      // Reset outputs mirror the reset register values so the two never disagree.
      pin0_ctrl.analog_select <= adc_ctrl_pkg::RST_PORT2[adc_ctrl_pkg::BIT_PIN0];
      pin0_ctrl.out_en <= !adc_ctrl_pkg::RST_PORT2[adc_ctrl_pkg::BIT_PIN0];
      conv_end_req.request <= 1'b0;
      conv_end_req.prio <= {adc_ctrl_pkg::RST_PRIO[adc_ctrl_pkg::BIT_CONV_END],
        adc_ctrl_pkg::RST_PRIO[adc_ctrl_pkg::BIT_CONV_END]};
      irq <= 1'b0;
    end else begin
      reg_rdata <= rdata_d;
      conv_ctrl <= conv_ctrl_d;
      pin0_ctrl <= pin0_ctrl_d;
      conv_end_req <= conv_end_req_d;
      irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the control behaviour.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  a_reset_hold_follow: assert property (
    reg_wr && reg_addr == adc_ctrl_pkg::OFF_PERIPH_RESET |=>
      conv_ctrl.reset_hold == $past(reg_wdata[5]) ##1 conv_ctrl.run == 1'b0 || !conv_ctrl.reset_hold)
    else $error("converter reset hold does not follow its control bit");

  a_gated_write_ignored: assert property (
    reg_wr && reg_addr == adc_ctrl_pkg::OFF_CONV_MODE && !conv_ctrl.clock_gate |=>
      $stable(converter_mode_0_q))
    else $error("converter mode changed while its clock was gated off");

  a_run_write_taken: assert property (
    reg_wr && reg_addr == adc_ctrl_pkg::OFF_CONV_MODE && conv_ctrl.clock_gate
      && !conv_ctrl.reset_hold |=> conv_ctrl.run == $past(reg_wdata[7]))
    else $error("conversion run output does not follow the written bit");

  a_run_readback: assert property (
    reg_rd && reg_addr == adc_ctrl_pkg::OFF_CONV_MODE |=> reg_rdata[7] == conv_ctrl.run)
    else $error("conversion run bit reads back wrong");

  a_comparator_follow: assert property (
    reg_wr && reg_addr == adc_ctrl_pkg::OFF_CONV_MODE && conv_ctrl.clock_gate
      && !conv_ctrl.reset_hold |=> conv_ctrl.comparator_enable == $past(reg_wdata[0]))
    else $error("comparator enable does not follow the written bit");

  a_mask_withholds: assert property (
    irq_mask_group1_high_q[0] |-> !conv_end_req.request)
    else $error("masked conversion end request reached the controller");

  a_flag_set_wins: assert property (
    done_evt |=> irq_request_group1_high_q[0] ##1 irq_request_group1_high_q[0]
      || $past(reg_wr && reg_addr == adc_ctrl_pkg::OFF_IRQ_REQUEST))
    else $error("conversion end did not set the request flag");

  a_prio_code: assert property (
    conv_end_req.prio == {irq_priority_upper_bits_q[0], irq_priority_lower_bits_q[0]})
    else $error("conversion end priority code is wrong");

  a_pin_analog: assert property (
    pin0_ctrl.analog_select == port2_analog_select_q[0])
    else $error("pin analog selection does not follow its bit");

  a_pin_output: assert property (
    !port2_direction_q[0] |-> pin0_ctrl.out_en)
    else $error("pin buffer off while direction selects output");

  a_pin_input: assert property (
    port2_direction_q[0] |-> !pin0_ctrl.out_en)
    else $error("pin buffer on while direction selects input");

  a_result_capture: assert property (
    done_evt |=> conversion_result_q == $past(data_s2_q))
    else $error("conversion result not captured at conversion end");

  a_flag_sw_clear: assert property (
    reg_wr && reg_addr == adc_ctrl_pkg::OFF_IRQ_REQUEST && !reg_wdata[0] && !done_evt |=>
      !irq_request_group1_high_q[adc_ctrl_pkg::BIT_CONV_END])
    else $error("software write of 0 did not clear the request flag");

  a_flag_pending_masked: assert property (
    done_evt && irq_mask_group1_high_d[adc_ctrl_pkg::BIT_CONV_END] |=>
      irq_request_group1_high_q[adc_ctrl_pkg::BIT_CONV_END] && !conv_end_req.request)
    else $error("masked conversion end did not leave a pending flag");

  a_status_end_set: assert property (
    done_evt |=> evt_status_q[adc_ctrl_pkg::BIT_EVT_END])
    else $error("conversion end did not set the event status bit");

  a_irq_level: assert property (
    irq == |(evt_status_q & evt_mask_q))
    else $error("interrupt output does not follow status and mask");

  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the read answer cycle");

endmodule

`default_nettype wire

/* adc_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: Offsets, field positions and reset values as the package names them.
// Notes: Random stimulus from a fixed seed with hand-made corner cases among it.
`timescale 1ns/1ns
`default_nettype none

module adc_ctrl_tb_top;
  logic core_clk;
  logic arst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic conv_done;
  logic [9:0] conv_data;
  adc_ctrl_pkg::conv_ctrl_t conv_ctrl;
  adc_ctrl_pkg::pin_ctrl_t pin0_ctrl;
  adc_ctrl_pkg::irq_req_t conv_end_req;
  logic irq;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed;
  logic [7:0] rv;
  logic [7:0] v5;
  logic [7:0] v6;
  logic [9:0] d;

  adc_ctrl #(.RESULT_W(10)) adc_ctrl_i (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .conv_done(conv_done),
    .conv_data(conv_data),
    .conv_ctrl(conv_ctrl),
    .pin0_ctrl(pin0_ctrl),
    .conv_end_req(conv_end_req),
    .irq(irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h03, 8'h05, 8'h06, 8'h07, 8'h08: rst_val = 8'hff;
      default: rst_val = 8'h00;
    endcase
  endfunction

  task automatic wrap_up();
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // Data settle well before the conversion-end level rises and stay until it falls.
  task automatic conv_event(input logic [9:0] x);
    @(posedge core_clk);
    conv_data <= x;
    repeat (4) @(posedge core_clk);
    conv_done <= 1'b1;
    repeat (4) @(posedge core_clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    seed = 70;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    conv_done = 1'b0;
    conv_data = 10'h000;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("pin0_analog", 16'(pin0_ctrl.analog_select), 16'h1);
    chk("pin0_out_en", 16'(pin0_ctrl.out_en), 16'h0);
    chk("prio_reset", 16'(conv_end_req.prio), 16'h3);
    for (int a = 0; a < 14; a++) begin
      rd_chk("reset_value", a[7:0], rst_val(a[7:0]));
    end
    rd_chk("unmapped", 8'h3c, 8'h00);

    // Random register contents; the low bits of the priority pair walk all four codes.
    for (int i = 0; i < 8; i++) begin
      rv = 8'($random(seed));
      v5 = {rv[7:1], i[1]};
      v6 = {rv[6:0], i[0]};
      wr(adc_ctrl_pkg::OFF_PRIO_UPPER, v5);
      wr(adc_ctrl_pkg::OFF_PRIO_LOWER, v6);
      chk("prio", 16'(conv_end_req.prio), {14'h0, v5[0], v6[0]});
      rd_chk("prio_upper", adc_ctrl_pkg::OFF_PRIO_UPPER, v5);
      rd_chk("prio_lower", adc_ctrl_pkg::OFF_PRIO_LOWER, v6);
      wr(adc_ctrl_pkg::OFF_PORT2_ANALOG, v5);
      wr(adc_ctrl_pkg::OFF_PORT2_DIR, v6);
      chk("pin0_analog", 16'(pin0_ctrl.analog_select), 16'(v5[0]));
      chk("pin0_out_en", 16'(pin0_ctrl.out_en), {15'h0000, !v6[0]});
      rd_chk("port2_dir", adc_ctrl_pkg::OFF_PORT2_DIR, v6 | 8'hf0);
      rd_chk("port2_analog", adc_ctrl_pkg::OFF_PORT2_ANALOG, v5 | 8'hf0);
      wr(adc_ctrl_pkg::OFF_PERIPH_RESET, rv);
      chk("reset_hold", 16'(conv_ctrl.reset_hold), 16'(rv[5]));
      rd_chk("periph_reset", adc_ctrl_pkg::OFF_PERIPH_RESET, rv & 8'h75);
      wr(adc_ctrl_pkg::OFF_PERIPH_CLOCK, v6);
      chk("clock_gate", 16'(conv_ctrl.clock_gate), 16'(v6[5]));
      rd_chk("periph_clock", adc_ctrl_pkg::OFF_PERIPH_CLOCK, v6 & 8'h75);
    end

    // Mode writes are refused while the clock is off or the reset is held.
    wr(adc_ctrl_pkg::OFF_PERIPH_RESET, 8'h00);
    wr(adc_ctrl_pkg::OFF_PERIPH_CLOCK, 8'h00);
    wr(adc_ctrl_pkg::OFF_CONV_MODE, 8'h81);
    chk("run_gated", 16'(conv_ctrl.run), 16'h0);
    rd_chk("mode_gated", adc_ctrl_pkg::OFF_CONV_MODE, 8'h00);
    wr(adc_ctrl_pkg::OFF_PERIPH_CLOCK, 8'h20);
    wr(adc_ctrl_pkg::OFF_PERIPH_RESET, 8'h20);
    wr(adc_ctrl_pkg::OFF_CONV_MODE, 8'h81);
    rd_chk("mode_held", adc_ctrl_pkg::OFF_CONV_MODE, 8'h00);
    wr(adc_ctrl_pkg::OFF_PERIPH_RESET, 8'h00);
    chk("reset_free", 16'(conv_ctrl.reset_hold), 16'h0);
    wr(adc_ctrl_pkg::OFF_CONV_MODE, 8'h00);
    wr(adc_ctrl_pkg::OFF_CONV_MODE, 8'h81);
    chk("run_on", 16'(conv_ctrl.run), 16'h1);
    chk("comp_on", 16'(conv_ctrl.comparator_enable), 16'h1);
    rd_chk("mode_read", adc_ctrl_pkg::OFF_CONV_MODE, 8'h81);
    wr(adc_ctrl_pkg::OFF_CONV_MODE, 8'h01);
    chk("run_off", 16'(conv_ctrl.run), 16'h0);
    rd_chk("mode_stop", adc_ctrl_pkg::OFF_CONV_MODE, 8'h01);
    wr(adc_ctrl_pkg::OFF_CONV_MODE, 8'h80);
    chk("comp_off", 16'(conv_ctrl.comparator_enable), 16'h0);

    // Masked conversion end: flag still sets, request stays low.
    rd_chk("result_high_idle", adc_ctrl_pkg::OFF_RESULT_HIGH, 8'h00);
    d = 10'($random(seed));
    conv_event(d);
    chk("req_masked", 16'(conv_end_req.request), 16'h0);
    rd_chk("flag_masked", adc_ctrl_pkg::OFF_IRQ_REQUEST, 8'h01);
    rd_chk("result_high", adc_ctrl_pkg::OFF_RESULT_HIGH, d[9:2]);
    rd_chk("result_low", adc_ctrl_pkg::OFF_RESULT_LOW, {d[1:0], 6'h00});
    chk("irq_disabled", 16'(irq), 16'h0);
    rd_chk("status_set", adc_ctrl_pkg::OFF_EVT_STATUS, 8'h01);
    rd_chk("status_clear", adc_ctrl_pkg::OFF_EVT_STATUS, 8'h00);
    wr(adc_ctrl_pkg::OFF_IRQ_MASK, 8'hfe);
    chk("req_unmasked", 16'(conv_end_req.request), 16'h1);
    wr(adc_ctrl_pkg::OFF_IRQ_REQUEST, 8'h00);
    chk("req_cleared", 16'(conv_end_req.request), 16'h0);
    rd_chk("flag_cleared", adc_ctrl_pkg::OFF_IRQ_REQUEST, 8'h00);

    // Interrupt raised, masked, unmasked, then cleared by reading status.
    wr(adc_ctrl_pkg::OFF_EVT_MASK, 8'h01);
    conv_event(~d);
    chk("irq_on", 16'(irq), 16'h1);
    chk("req_event", 16'(conv_end_req.request), 16'h1);
    wr(adc_ctrl_pkg::OFF_EVT_MASK, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq_masked", 16'(irq), 16'h0);
    wr(adc_ctrl_pkg::OFF_EVT_MASK, 8'h01);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq_back", 16'(irq), 16'h1);
    conv_event(d);
    rd_chk("status_overrun", adc_ctrl_pkg::OFF_EVT_STATUS, 8'h03);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq_cleared", 16'(irq), 16'h0);
    rd_chk("result_second", adc_ctrl_pkg::OFF_RESULT_HIGH, d[9:2]);

    // An end event with the clock gated off is dropped.
    wr(adc_ctrl_pkg::OFF_IRQ_REQUEST, 8'h00);
    wr(adc_ctrl_pkg::OFF_PERIPH_CLOCK, 8'h00);
    conv_event(~d);
    wr(adc_ctrl_pkg::OFF_PERIPH_CLOCK, 8'h20);
    rd_chk("flag_gated", adc_ctrl_pkg::OFF_IRQ_REQUEST, 8'h00);
    rd_chk("status_gated", adc_ctrl_pkg::OFF_EVT_STATUS, 8'h00);
    wrap_up();
  end
endmodule

`default_nettype wire
